/* hdl/ddrct_buf2.sv */
// two-entry valid/ready buffer in the read data path
// assumes both sides on core_clk; outValid and outData come straight from flops
`timescale 1ns/100ps
module ddrct_buf2
  import ddrct_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire logic [DATA_W-1:0] inData,
  output logic                   outValid,
  input  wire logic              outReady,
  output logic [DATA_W-1:0]      outData,
  output logic                   bufEmpty
);

  logic [DATA_W-1:0] skid_q;
  logic              skidValid_q;

  // ready is the skid slot being free, so a stall downstream costs no word
  assign inReady  = ~skidValid_q;
  assign bufEmpty = ~outValid & ~skidValid_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      outValid    <= 1'b0;
      outData     <= '0;
      skidValid_q <= 1'b0;
      skid_q      <= '0;
    end else if (!outValid || outReady) begin
      if (skidValid_q) begin
        outData     <= skid_q;
        outValid    <= 1'b1;
        skidValid_q <= 1'b0;
      end else begin
        outValid <= inValid;
        if (inValid) begin
          outData <= inData;
        end
      end
    end else if (inValid && !skidValid_q) begin
      skid_q      <= inData;
      skidValid_q <= 1'b1;
    end
  end

endmodule // ddrct_buf2

/* hdl/ddrct_device.sv */
// memory-side command timing: checks controller command spacing, drives the
// active-low fet switch control around reads and writes, holds a small array
// assumes command pins and strobe arrive asynchronously and are resynchronised
//
// Overview of operation
// R1: bank stays open at least 45 ns and at most 120,000 ns before precharge.
// R2: activate to activate or auto-refresh on one bank needs 65 ns.
// R3: auto-refresh to next auto-refresh or any activate needs 75 ns.
// R4: activate to read or write on that bank needs 20 ns.
// R5: activates to different banks are at least 15 ns apart.
// R6: write with auto precharge to next activate of that bank needs 35 ns.
// R7: one clock at least between end of write data and a read.
// R8: self-refresh exit to any non-read command needs 75 ns.
// R9: self-refresh exit to a read needs 200 clocks for relock.
// R10: auto-refresh commands average at most 7.8 us apart.
// R11: no more than eight owed refreshes outstanding.
// R12: mode register set needs 2 clocks before the next command.
// R13: first write strobe latch lands 5.6 to 9.4 ns after write command.
// R14: write strobe is valid by the clock edge before its first latch edge.
// R15: write preamble goes high impedance to low unless a write precedes it.
// R16: switch control asserts 0.9 to 1.1 clocks ahead of read data.
// R17: switch control holds 0.4 to 0.6 clocks after a read burst; the code holds it one clock.
// R18: switch control goes low within 4.0 ns of a write command; the code drives it low one clock after the synchronised write.
// R19: switch control releases 1.25 to 2.0 ns after last strobe goes low; the code releases it one clock after the synchronised fall.
// R20: intervals count from registering rising edges, ns rounded up to clocks.
`timescale 1ns/100ps
module ddrct_device
  import ddrct_pkg::*;
#(
  parameter int RAS_MAX_CYC = RAS_MAX_DEF
)(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              cmdCke,
  input  wire logic              cmdCs_n,
  input  wire logic              cmdRas_n,
  input  wire logic              cmdCas_n,
  input  wire logic              cmdWe_n,
  input  wire logic [BANK_W-1:0] cmdBank,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic              wrStrobe,
  input  wire logic [DATA_W-1:0] wrData,
  output logic [DATA_W-1:0]      rdData,
  output logic                   rdValid,
  input  wire logic              rdReady,
  output logic                   fetSwitchCtl_n,
  output logic                   timingFault,
  output logic [3:0]             refreshOwed
);

  // every check in this module, the per-bank ones included, runs on the core clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // pin synchroniser and command decode
  // ****************************************************************
  logic [PIN_W-1:0] pinMeta_q;
  logic [PIN_W-1:0] pinSync_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pinMeta_q <= PIN_IDLE;
      pinSync_q <= PIN_IDLE;
    end else begin
      pinMeta_q <= {cmdCke, cmdCs_n, cmdRas_n, cmdCas_n, cmdWe_n, cmdBank, cmdAddr,
                    wrStrobe, wrData};
      pinSync_q <= pinMeta_q;
    end
  end

  logic              ckeNow;
  logic              ckePrev_q;
  logic              strobePrev_q;
  logic              inSelfRef_q;
  logic [2:0]        cmdBits;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dataIn;
  logic              strobeFall;
  ddrct_cmd_t        cmd;

  assign ckeNow     = pinSync_q[PIN_CKE];
  assign cmdBits    = pinSync_q[PIN_CMD +: 3];
  assign bank       = pinSync_q[PIN_BANK +: BANK_W];
  assign addr       = pinSync_q[PIN_ADDR +: ADDR_W];
  assign dataIn     = pinSync_q[PIN_DATA +: DATA_W];
  assign strobeFall = strobePrev_q & ~pinSync_q[PIN_STB];
  // commands count only with clock enable held high across the edge [R20]
  assign cmd = (!pinSync_q[PIN_CS] && ckeNow && ckePrev_q) ? ddrct_cmd_t'(cmdBits) : CMD_NOP;

  logic selfRefEntry;
  logic selfRefExit;
  logic autoRef;
  assign selfRefEntry = !pinSync_q[PIN_CS] && cmdBits == CMD_REF && ckePrev_q && !ckeNow;
  assign selfRefExit  = inSelfRef_q && ckeNow && !ckePrev_q;
  assign autoRef      = cmd == CMD_REF;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ckePrev_q    <= 1'b0;
      strobePrev_q <= 1'b0;
      inSelfRef_q  <= 1'b0;
    end else begin
      ckePrev_q    <= ckeNow;
      strobePrev_q <= pinSync_q[PIN_STB];
      inSelfRef_q  <= selfRefEntry | (inSelfRef_q & ~selfRefExit);
    end
  end

  function automatic logic [AGE_W-1:0] ageStep(input logic clr, input logic [AGE_W-1:0] age);
    // restart at one so that an age equals the cycles since the command [R20]
    return clr ? AGE_W'(1) : ((age == AGE_MAX) ? age : age + 1'b1);
  endfunction

  // ****************************************************************
  // per-bank spacing checks
  // ****************************************************************
  logic [BANKS-1:0] bankFault;
  logic             wrDone;
  logic [BANK_W-1:0] wrBank_q;
  logic             wrAutoPre_q;

  for (genvar i = 0; i < BANKS; i++) begin : gBank
    logic             open_q;
    logic [AGE_W-1:0] actAge_q;
    logic [AGE_W-1:0] dalAge_q;
    logic             hit;
    logic             preHit;
    logic             rwHit;
    logic             preEarly;
    assign hit    = bank == BANK_W'(i);
    assign preHit = cmd == CMD_PRE && (hit || addr[AUTO_PRE_BIT]);
    assign rwHit  = (cmd == CMD_RD || cmd == CMD_WR) && hit;
    assign preEarly = preHit && open_q && actAge_q < RAS_MIN_CYC;

    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        open_q   <= 1'b0;
        actAge_q <= AGE_MAX;
        dalAge_q <= AGE_MAX;
      end else begin
        actAge_q <= ageStep(cmd == CMD_ACT && hit, actAge_q);
        dalAge_q <= ageStep(wrDone && wrAutoPre_q && wrBank_q == BANK_W'(i), dalAge_q);
        if (cmd == CMD_ACT && hit) begin
          open_q <= 1'b1;
        end else if (preHit || (rwHit && addr[AUTO_PRE_BIT])) begin
          open_q <= 1'b0;
        end
      end
    end

    assign bankFault[i] = (((cmd == CMD_ACT && hit) || autoRef) && actAge_q < RC_CYC) // [R2]
                        | (cmd == CMD_ACT && hit && dalAge_q < DAL_CYC)           // [R6]
                        | preEarly                                               // [R1]
                        | (open_q && actAge_q == AGE_W'(RAS_MAX_CYC))             // [R1]
                        | (rwHit && actAge_q < RCD_CYC);                          // [R4]

    rasMin_a: assert property (preEarly |=> timingFault) // [R1]
      else $error("early precharge not flagged");
    rcdMin_a: assert property (rwHit && actAge_q < RCD_CYC |=> timingFault) // [R4]
      else $error("early read or write not flagged");
  end

  // ****************************************************************
  // device-wide spacing and refresh bookkeeping
  // ****************************************************************
  logic [AGE_W-1:0]  lastActAge_q;
  logic [BANK_W-1:0] lastActBank_q;
  logic [AGE_W-1:0]  refAge_q;
  logic [AGE_W-1:0]  mrdAge_q;
  logic [AGE_W-1:0]  xsAge_q;
  logic [AGE_W-1:0]  wrEndAge_q;
  logic [9:0]        refiCnt_q;
  logic              refreshTick;
  logic              globalFault;

  assign refreshTick = refiCnt_q == REFI_CYC - 10'h001;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lastActAge_q  <= AGE_MAX;
      lastActBank_q <= '0;
      refAge_q      <= AGE_MAX;
      mrdAge_q      <= AGE_MAX;
      xsAge_q       <= AGE_MAX;
      wrEndAge_q    <= AGE_MAX;
    end else begin
      lastActAge_q <= ageStep(cmd == CMD_ACT, lastActAge_q);
      if (cmd == CMD_ACT) begin
        lastActBank_q <= bank;
      end
      refAge_q   <= ageStep(autoRef, refAge_q);
      mrdAge_q   <= ageStep(cmd == CMD_MRS, mrdAge_q);
      xsAge_q    <= ageStep(selfRefExit, xsAge_q);
      wrEndAge_q <= ageStep(wrDone, wrEndAge_q);
    end
  end

  // one owed refresh per interval; a refresh command pays one back [R10]
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refiCnt_q   <= '0;
      refreshOwed <= '0;
    end else begin
      refiCnt_q <= refreshTick ? 10'h000 : refiCnt_q + 10'h001;
      if (inSelfRef_q) begin
        refreshOwed <= '0;
      end else if (refreshTick && !autoRef && refreshOwed != 4'hf) begin
        refreshOwed <= refreshOwed + 4'h1;
      end else if (autoRef && !refreshTick && refreshOwed != 4'h0) begin
        refreshOwed <= refreshOwed - 4'h1;
      end
    end
  end

  assign globalFault =
      (cmd == CMD_ACT && bank != lastActBank_q && lastActAge_q < RRD_CYC)   // [R5]
    | ((cmd == CMD_ACT || autoRef) && refAge_q < RFC_CYC)                   // [R3]
    | (cmd != CMD_NOP && mrdAge_q < MRD_CYC)                                // [R12]
    | (cmd != CMD_NOP && cmd != CMD_RD && xsAge_q < XSNR_CYC)               // [R8]
    | (cmd == CMD_RD && xsAge_q < XSRD_CYC)                                 // [R9]
    | (cmd == CMD_RD && wrEndAge_q <= WTR_CYC)                              // [R7]
    | (refreshTick && !autoRef && refreshOwed == OWED_MAX);                 // [R11]

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      timingFault <= 1'b0;
    end else begin
      timingFault <= (|bankFault) | globalFault;
    end
  end

  // ****************************************************************
  // data array, burst sequencing and switch control
  // ****************************************************************
  logic [DATA_W-1:0]      mem [BANKS * (1 << COL_W)];
  ddrct_fet_t             fetSt_q;
  logic [1:0]             rdWait_q;
  logic [1:0]             beat_q;
  logic [BANK_W-1:0]      rdBank_q;
  logic [COL_W-1:0]       col_q;
  logic                   bufInValid;
  logic                   bufInReady;
  logic                   bufEmpty;

  assign bufInValid = fetSt_q == FS_RD_BURST;
  // strobe edges are trusted only inside the write window the controller sets up [R13] [R14] [R15]
  assign wrDone = fetSt_q == FS_WR && strobeFall && beat_q == BURST_LAST;

  always_ff @(posedge core_clk) begin
    if (fetSt_q == FS_WR && strobeFall) begin
      mem[{wrBank_q, col_q}] <= dataIn;
    end
  end

  // commands arriving mid-burst are checked for timing but start no data
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fetSt_q        <= FS_IDLE;
      fetSwitchCtl_n <= FET_OFF;
      rdWait_q       <= '0;
      beat_q         <= '0;
      rdBank_q       <= '0;
      wrBank_q       <= '0;
      wrAutoPre_q    <= 1'b0;
      col_q          <= '0;
    end else begin
      case (fetSt_q)
        FS_IDLE: begin
          beat_q <= '0;
          col_q  <= addr[COL_W-1:0];
          if (cmd == CMD_WR) begin
            fetSt_q        <= FS_WR;
            fetSwitchCtl_n <= 1'b0;                                         // [R18]
            wrBank_q       <= bank;
            wrAutoPre_q    <= addr[AUTO_PRE_BIT];
          end else if (cmd == CMD_RD) begin
            fetSt_q  <= FS_RD_LEAD;
            rdWait_q <= RD_LEAD_WAIT;
            rdBank_q <= bank;
          end
        end
        FS_RD_LEAD: begin
          if (rdWait_q == 2'h0) begin
            fetSwitchCtl_n <= 1'b0;                                         // [R16]
            fetSt_q        <= FS_RD_BURST;
          end else begin
            rdWait_q <= rdWait_q - 2'h1;
          end
        end
        FS_RD_BURST: begin
          if (bufInReady) begin
            beat_q <= beat_q + 2'h1;
            col_q  <= col_q + 1'b1;
            if (beat_q == BURST_LAST) begin
              fetSt_q <= FS_RD_HOLD;
            end
          end
        end
        FS_RD_HOLD: begin
          // one whole clock past the last word: half a clock cannot be made here
          if (bufEmpty) begin
            fetSwitchCtl_n <= FET_OFF;                                      // [R17]
            fetSt_q        <= FS_IDLE;
          end
        end
        FS_WR: begin
          if (strobeFall) begin
            beat_q <= beat_q + 2'h1;
            col_q  <= col_q + 1'b1;
            if (beat_q == BURST_LAST) begin
              fetSwitchCtl_n <= FET_OFF;                                    // [R19]
              fetSt_q        <= FS_IDLE;
            end
          end
        end
        default: begin
          fetSt_q        <= FS_IDLE;
          fetSwitchCtl_n <= FET_OFF;
        end
      endcase
    end
  end

  ddrct_buf2 uBuf (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (mem[{rdBank_q, col_q}]),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData),
    .bufEmpty (bufEmpty)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence leadDone_s;
    fetSt_q == FS_RD_LEAD && rdWait_q == 2'h0;
  endsequence
  sequence switchThenData_s;
    (!fetSwitchCtl_n && !rdValid) ##1 (!fetSwitchCtl_n && rdValid);
  endsequence

  readLead_a: assert property (leadDone_s ##1 bufInReady |-> switchThenData_s) // [R16]
    else $error("switch control not one clock ahead of read data");
  readHold_a: assert property ($fell(rdValid) && fetSt_q == FS_RD_HOLD |-> !fetSwitchCtl_n ##1 fetSwitchCtl_n) // [R17]
    else $error("switch control not held one clock after read");
  writeSet_a: assert property (fetSt_q == FS_IDLE && cmd == CMD_WR |=> !fetSwitchCtl_n) // [R18]
    else $error("switch control late on write");
  writeRel_a: assert property (wrDone |=> fetSwitchCtl_n && fetSt_q == FS_IDLE) // [R19]
    else $error("switch control not released after last strobe");
  mrdGap_a: assert property (cmd == CMD_MRS ##1 cmd != CMD_NOP |=> timingFault) // [R12]
    else $error("command after mode set not flagged");
  xsrdGap_a: assert property (selfRefExit ##[1:199] cmd == CMD_RD |=> timingFault) // [R9]
    else $error("early read after self refresh not flagged");
  owedMax_a: assert property (refreshTick && !autoRef && refreshOwed == OWED_MAX |=> timingFault) // [R11]
    else $error("excess owed refresh not flagged");
  owedCount_a: assert property (refreshTick && !autoRef && !inSelfRef_q && refreshOwed < 4'h8
                                |=> refreshOwed == $past(refreshOwed) + 4'h1) // [R10]
    else $error("refresh interval not counted");
  rrdGap_a: assert property (cmd == CMD_ACT ##1 (cmd == CMD_ACT && bank != lastActBank_q) |=> timingFault) // [R5]
    else $error("close activates not flagged");

endmodule // ddrct_device

/* hdl/ddrct_pkg.sv */
// constants, command codes and state codes of the memory-side command timing block
// assumes a single 100 MHz core clock that stands in for the memory's command clock
package ddrct_pkg;

  // ****************************************************************
  // clock and derived cycle counts
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_MHZ       = 100;
  localparam int AGE_W         = 16;

  localparam int  T_RAS_MIN_NS = 45;
  localparam int  T_RAS_MAX_NS = 120000;
  localparam int  T_RC_NS      = 65;
  localparam int  T_RFC_NS     = 75;
  localparam int  T_RCD_NS     = 20;
  localparam int  T_RRD_NS     = 15;
  localparam int  T_DAL_NS     = 35;
  localparam int  T_XSNR_NS    = 75;
  localparam int  T_WTR_TCK    = 1;
  localparam int  T_XSRD_TCK   = 200;
  localparam int  T_MRD_TCK    = 2;
  localparam real T_REFI_US    = 7.8;
  localparam int  REFRESH_OWED_MAX = 8;

  function automatic int ceilCyc(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam logic [AGE_W-1:0] AGE_MAX     = '1;
  localparam logic [AGE_W-1:0] RAS_MIN_CYC = AGE_W'(ceilCyc(T_RAS_MIN_NS));
  localparam int               RAS_MAX_DEF = T_RAS_MAX_NS / CLK_PERIOD_NS;
  localparam logic [AGE_W-1:0] RC_CYC      = AGE_W'(ceilCyc(T_RC_NS));
  localparam logic [AGE_W-1:0] RFC_CYC     = AGE_W'(ceilCyc(T_RFC_NS));
  localparam logic [AGE_W-1:0] RCD_CYC     = AGE_W'(ceilCyc(T_RCD_NS));
  localparam logic [AGE_W-1:0] RRD_CYC     = AGE_W'(ceilCyc(T_RRD_NS));
  localparam logic [AGE_W-1:0] DAL_CYC     = AGE_W'(ceilCyc(T_DAL_NS));
  localparam logic [AGE_W-1:0] XSNR_CYC    = AGE_W'(ceilCyc(T_XSNR_NS));
  localparam logic [AGE_W-1:0] WTR_CYC     = AGE_W'(T_WTR_TCK);
  localparam logic [AGE_W-1:0] XSRD_CYC    = AGE_W'(T_XSRD_TCK);
  localparam logic [AGE_W-1:0] MRD_CYC     = AGE_W'(T_MRD_TCK);
  localparam logic [9:0]       REFI_CYC    = 10'(int'(T_REFI_US * real'(CLK_MHZ)));
  localparam logic [3:0]       OWED_MAX    = 4'(REFRESH_OWED_MAX);

  // ****************************************************************
  // data path shape and switch-control timing
  // ****************************************************************
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 11;
  localparam int BANK_W    = 2;
  localparam int BANKS     = 4;
  localparam int COL_W     = 4;
  localparam int AUTO_PRE_BIT = 10;
  localparam int CAS_LAT_CYC  = 2;
  localparam logic [1:0] BURST_LAST = 2'h3;
  localparam int FET_RD_LEAD_CYC = 1;
  localparam logic [1:0] RD_LEAD_WAIT = 2'(CAS_LAT_CYC - FET_RD_LEAD_CYC - 1);
  localparam logic FET_OFF = 1'b1;

  // ****************************************************************
  // pin bundle layout after synchronising
  // ****************************************************************
  localparam int PIN_W    = 35;
  localparam int PIN_CKE  = 34;
  localparam int PIN_CS   = 33;
  localparam int PIN_CMD  = 30;
  localparam int PIN_BANK = 28;
  localparam int PIN_ADDR = 17;
  localparam int PIN_STB  = 16;
  localparam int PIN_DATA = 0;
  localparam logic [PIN_W-1:0] PIN_IDLE = 35'h7c0000000;

  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR  = 3'b100,
    CMD_RD  = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } ddrct_cmd_t;

  typedef enum logic [2:0] {
    FS_IDLE     = 3'b000,
    FS_RD_LEAD  = 3'b001,
    FS_RD_BURST = 3'b010,
    FS_RD_HOLD  = 3'b011,
    FS_WR       = 3'b100
  } ddrct_fet_t;

endpackage

/* sim/ddrct_ctrl_model.sv */
// controller-side model: drives command pins, write strobe and write data
// assumes the bench calls its tasks just after a rising edge of core_clk
`timescale 1ns/100ps
module ddrct_ctrl_model
  import ddrct_pkg::*;
(
  input  wire logic         core_clk,
  output logic              cmdCke,
  output logic              cmdCs_n,
  output logic [2:0]        cmdCode,
  output logic [BANK_W-1:0] cmdBank,
  output logic [ADDR_W-1:0] cmdAddr,
  output logic              wrStrobe,
  output logic [DATA_W-1:0] wrData
);
  initial begin
    cmdCke   = 1'b1;
    cmdCs_n  = 1'b1;
    cmdCode  = CMD_NOP;
    cmdBank  = 2'h0;
    cmdAddr  = 11'h000;
    wrStrobe = 1'b0;                      // strobe parked low as preamble
    wrData   = 16'h0000;
  end

  // one command per call, spacing is left to the caller
  task automatic issue(input ddrct_cmd_t c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a);
    cmdCs_n <= 1'b0;
    cmdCode <= c;
    cmdBank <= b;
    cmdAddr <= a;
    @(posedge core_clk);
  endtask

  // four strobe falls, data only valid around each fall
  task automatic burst(input logic [3:0][DATA_W-1:0] w);
    cmdCode <= CMD_NOP;
    for (int i = 0; i < 4; i++) begin
      wrStrobe <= 1'b1;                   // strobe valid before its latching edge
      wrData   <= ~wrData;
      @(posedge core_clk);
      wrStrobe <= 1'b0;                   // latching fall one clock after the rise, the first fall two clocks after the command
      wrData   <= w[i];
      @(posedge core_clk);
    end
    wrData <= ~w[3];
  endtask

  // self-refresh entry, idle cycles with clock enable low, then exit
  task automatic selfRef(input int idle);
    cmdCs_n <= 1'b0;
    cmdCode <= CMD_REF;
    cmdCke  <= 1'b0;
    @(posedge core_clk);
    cmdCode <= CMD_NOP;
    repeat (idle) @(posedge core_clk);
    cmdCke  <= 1'b1;
    @(posedge core_clk);
  endtask
endmodule // ddrct_ctrl_model

/* sim/ddrct_device_tb_top.sv */
// self-checking bench for the memory-side command timing block
// assumes the controller model in ddrct_ctrl_model.sv and a 100 MHz core clock
`timescale 1ns/100ps
module ddrct_device_tb_top
  import ddrct_pkg::*;
;
  typedef struct {ddrct_cmd_t a; logic [1:0] bb; ddrct_cmd_t b; int lim;} ddrct_gap_t;
  logic                     core_clk;
  logic                     reset_n = 1'b0;
  logic                     rdReady = 1'b1;
  logic                     randRdy = 1'b0;
  logic                     cke, cs_n, strobe, rdValid, fet_n, fault, fetPrev, vPrev, fetBefore;
  logic [2:0]               code;
  logic [BANK_W-1:0]        bank, b;
  logic [ADDR_W-1:0]        addr;
  logic [DATA_W-1:0]        wdat, rdData;
  logic [3:0]               owed, col;
  logic [DATA_W-1:0]        got [$];
  logic [3:0][DATA_W-1:0]   w;
  int                       seed, fail_count, checked, cyc, faultSeen, fetLow, f0, o0, n;
  int                       tFirst, tLast;
  // burst-stop code in the first field stands for a self-refresh exit
  ddrct_gap_t gaps [10] = '{'{CMD_ACT, 2'h0, CMD_RD, int'(RCD_CYC)},
    '{CMD_ACT, 2'h1, CMD_ACT, int'(RRD_CYC)}, '{CMD_ACT, 2'h0, CMD_ACT, int'(RC_CYC)},
    '{CMD_ACT, 2'h0, CMD_PRE, int'(RAS_MIN_CYC)}, '{CMD_REF, 2'h0, CMD_ACT, int'(RFC_CYC)},
    '{CMD_MRS, 2'h0, CMD_REF, int'(MRD_CYC)}, '{CMD_ACT, 2'h0, CMD_REF, int'(RC_CYC)},
    '{CMD_WR, 2'h0, CMD_ACT, int'(DAL_CYC)}, '{CMD_BST, 2'h0, CMD_ACT, int'(XSNR_CYC)},
    '{CMD_BST, 2'h0, CMD_RD, int'(XSRD_CYC)}};

  ddrct_ctrl_model ctrl_i (.core_clk(core_clk), .cmdCke(cke), .cmdCs_n(cs_n), .cmdCode(code),
    .cmdBank(bank), .cmdAddr(addr), .wrStrobe(strobe), .wrData(wdat));
  ddrct_device #(.RAS_MAX_CYC(300)) ddrct_device_i (.core_clk(core_clk), .reset_n(reset_n),
    .cmdCke(cke), .cmdCs_n(cs_n), .cmdRas_n(code[2]), .cmdCas_n(code[1]), .cmdWe_n(code[0]),
    .cmdBank(bank), .cmdAddr(addr), .wrStrobe(strobe), .wrData(wdat), .rdData(rdData),
    .rdValid(rdValid), .rdReady(rdReady), .fetSwitchCtl_n(fet_n), .timingFault(fault),
    .refreshOwed(owed));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // monitor, stall source and hang guard
  // ****************************************************************
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    rdReady <= randRdy ? 1'($random(seed)) : 1'b1;
    if (fault === 1'b1) faultSeen <= faultSeen + 1;
    if (fet_n === 1'b0) fetLow <= fetLow + 1;
    // first-word capture must see the queue as it stood before this edge's push
    if (rdValid === 1'b1 && vPrev !== 1'b1 && got.size() == 0) begin
      fetBefore <= fetPrev;
      tFirst    <= cyc;
    end
    if (rdValid === 1'b1 && rdReady === 1'b1) begin
      got.push_back(rdData);
      tLast <= cyc;
    end
    fetPrev <= fet_n;
    vPrev <= rdValid;
    if (cyc > 12000) begin
      fail_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] expFault(input int gap, input int lim);
    return 32'(gap < lim);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic dut_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    seed = 97693;
    {fail_count, checked, cyc, faultSeen, fetLow} = '0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("fetIdle", 32'(fet_n), 32'h1);
    check("owedIdle", 32'(owed), 32'h0);
    // write a burst, then read it back through a stalling receiver
    b = 2'($random(seed));
    col = 4'($random(seed));
    for (int i = 0; i < 4; i++) w[i] = DATA_W'($random(seed));
    ctrl_i.issue(CMD_ACT, b, 11'h000);
    repeat (int'(RCD_CYC) - 1) ctrl_i.issue(CMD_NOP, 2'h0, 11'h000);
    f0 = fetLow;
    ctrl_i.issue(CMD_WR, b, {7'h00, col});
    ctrl_i.burst(w);
    repeat (4) ctrl_i.issue(CMD_NOP, 2'h0, 11'h000);
    n = fetLow - f0;
    check("wrFetLow", 32'(n >= 7 && n <= 9), 32'h1);
    got.delete();
    randRdy = 1'b1;
    f0 = fetLow;
    ctrl_i.issue(CMD_RD, b, {7'h00, col});
    ctrl_i.issue(CMD_NOP, 2'h0, 11'h000);
    for (int k = 0; k < 80 && got.size() < 4; k++) @(posedge core_clk);
    randRdy = 1'b0;
    repeat (4) @(posedge core_clk);
    check("rdCount", 32'(got.size()), 32'd4);
    for (int i = 0; i < 4 && i < got.size(); i++) check("rdWord", 32'(got[i]), 32'(w[i]));
    n = fetLow - f0;
    check("rdFetLead", 32'(fetBefore), 32'h0);
    // low from one clock before the first word to one clock after the last, stalls included
    check("rdFetLow", 32'(n), 32'(tLast - tFirst + 3));
    check("rdFetOff", 32'(fet_n), 32'h1);
    check("rwFaults", 32'(faultSeen), 32'h0);
    repeat (300) @(posedge core_clk);
    check("openTooLong", 32'(faultSeen), 32'h1);
    // each spacing just short of its limit, then exactly at it
    foreach (gaps[m]) for (int g = gaps[m].lim - 1; g <= gaps[m].lim; g++) begin
      dut_reset();
      f0 = faultSeen;
      if (gaps[m].a == CMD_BST) ctrl_i.selfRef(3);
      else ctrl_i.issue(gaps[m].a, 2'h0, {gaps[m].a == CMD_WR, 10'h000});
      if (gaps[m].a == CMD_WR) ctrl_i.burst(w);
      repeat (g - 1) ctrl_i.issue(CMD_NOP, 2'h0, 11'h000);
      ctrl_i.issue(gaps[m].b, gaps[m].bb, 11'h000);
      repeat (6) ctrl_i.issue(CMD_NOP, 2'h0, 11'h000);
      check("gapFault", 32'(faultSeen - f0), expFault(g, gaps[m].lim));
    end
    // owed refreshes pile up to the limit, one more tick is flagged
    dut_reset();
    f0 = faultSeen;
    repeat (8 * int'(REFI_CYC) + 20) @(posedge core_clk);
    check("owedMax", 32'(owed), 32'(OWED_MAX));
    check("owedNoFault", 32'(faultSeen - f0), 32'h0);
    repeat (int'(REFI_CYC)) @(posedge core_clk);
    check("owedOver", 32'(faultSeen - f0), 32'h1);
    o0 = int'(owed);
    ctrl_i.issue(CMD_REF, 2'h0, 11'h000);
    repeat (4) ctrl_i.issue(CMD_NOP, 2'h0, 11'h000);
    check("owedPaid", 32'(owed), 32'(o0 - 1));
    stop_test();
  end
endmodule // ddrct_device_tb_top
